// File: rtl/rtcu_consts.vh
// constants for the rtc update and mode control block
// assumes a 20 MHz core clock and a 32768 Hz tick pin
//
// What this block does
// - update-in-progress rises 16 ticks before update
// - bit 7 read-only; host avoids time while set
// - 11x halts; 010 restarts, update 500ms later
// - rate field 3:0; zero never fires
// - periods per rate code table
// - inhibit bit suspends one-second updates
// - periodic enable gates periodic to interrupt
// - alarm enable gates alarm to interrupt
// - update-ended enable gates update to interrupt
// - format bit selects binary or bcd
// - hour bit selects 24 or 12 hour
// - dst bit enables hour adjustment
// - format bits change presentation only
// - format bits may change any time
// - flags record always; clear on read
// - summary flag is enabled flags ored
// - time stable over 999ms after update
// - 12-hour bit 7 marks afternoon
`ifndef RTCU_CONSTS_VH
`define RTCU_CONSTS_VH

// register indexes; byte address is four times the index
`define RTCU_IDX_UPDATE_CTRL 8'h0a
`define RTCU_IDX_MODE_CTRL 8'h0b
`define RTCU_IDX_EVENT_FLAGS 8'h0c

// update control fields
`define RTCU_UC_BUSY 7
`define RTCU_UC_DIV_HI 6
`define RTCU_UC_DIV_LO 4
`define RTCU_UC_RATE_HI 3
`define RTCU_UC_RATE_LO 0
`define RTCU_DIV_RUN 3'h2
`define RTCU_DIV_RESET 3'h0

// mode control fields
`define RTCU_MC_INHIBIT 7
`define RTCU_MC_PER_EN 6
`define RTCU_MC_ALM_EN 5
`define RTCU_MC_UPD_EN 4
`define RTCU_MC_BINARY 2
`define RTCU_MC_24H 1
`define RTCU_MC_DST 0
`define RTCU_MC_RESET 8'h00
`define RTCU_MC_WMASK 8'hf7

// event flag fields
`define RTCU_EF_IRQ 7
`define RTCU_EF_PER 6
`define RTCU_EF_ALM 5
`define RTCU_EF_UPD 4

// timing: busy lead and prescaler values in ticks of the 32768 Hz clock, restart delay in ms
`define RTCU_TICK_HZ 32768
`define RTCU_BUSY_LEAD_TICKS 15'd16
`define RTCU_RESTART_MS 500
`define RTCU_PRESCALE_LAST 15'h7fff
`define RTCU_PRESCALE_HALF 15'h4000

`endif

// File: rtl/rtcu_top.v
// rtc update/mode control: divider chain, update-in-progress,
// periodic rate, event flags and presentation modes, on apb.
// assumes tick_32k_pin is an asynchronous 32768 Hz square wave;
// block_enable, alarm_event and rtc_reset_event come from core_clk logic.
`timescale 1ns/10ps
`include "rtcu_consts.vh"

module rtcu_top (
  input wire core_clk,
  input wire resetn,
  input wire rtc_reset_event,
  input wire tick_32k_pin,
  input wire block_enable,
  input wire alarm_event,
  input wire [4:0] hour_count,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq_q,
  output reg update_strobe_q,
  output reg periodic_strobe_q,
  output reg update_busy_q,
  output reg binary_vs_decimal_select,
  output reg hour_24_select_q,
  output reg dst_enable_q,
  output reg [7:0] hour_present_q
);

  // restart delay expressed in ticks of the 32k clock
  localparam [31:0] RESTART_TICKS = (`RTCU_TICK_HZ * `RTCU_RESTART_MS) / 1000;
  localparam [14:0] BUSY_START = `RTCU_PRESCALE_LAST - `RTCU_BUSY_LEAD_TICKS + 15'h0001;

  // tick pin synchroniser and edge detect
  reg tick_s1_q;
  reg tick_s2_q;
  reg tick_s3_q;
  wire tick = tick_s2_q & ~tick_s3_q;

  always @(posedge core_clk) begin
    if (!resetn) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end else begin
      tick_s1_q <= tick_32k_pin;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  // control registers
  reg [2:0] divider_run_control_q;
  reg [2:0] divider_run_control_d;
  reg [3:0] periodic_period_field_q;
  reg [3:0] periodic_period_field_d;
  reg [7:0] mode_q;
  reg [7:0] mode_d;
  reg [14:0] prescale_q;
  reg [14:0] prescale_d;
  reg [2:0] flags_q;
  reg [2:0] flags_d;

  wire blk_reset = !resetn || rtc_reset_event;

  // apb decode
  wire [7:0] idx = {2'b00, paddr[7:2]};
  wire hit_uc = (idx == `RTCU_IDX_UPDATE_CTRL);
  wire hit_mc = (idx == `RTCU_IDX_MODE_CTRL);
  wire hit_ef = (idx == `RTCU_IDX_EVENT_FLAGS);
  wire mapped = (paddr[1:0] == 2'b00) && (hit_uc || hit_mc || hit_ef);
  wire setup = psel && !penable;
  wire done = psel && penable && pready;
  wire wr_ok = done && pwrite && mapped;
  wire wr_uc = wr_ok && hit_uc;
  wire wr_mc = wr_ok && hit_mc;
  wire rd_ef = done && !pwrite && mapped && hit_ef;

  wire halted = divider_run_control_q[2:1] == 2'b11;
  wire running = (divider_run_control_q == `RTCU_DIV_RUN) && block_enable;
  wire [2:0] new_div = pwdata[`RTCU_UC_DIV_HI:`RTCU_UC_DIV_LO];
  // a restart only counts when leaving the halted state; writing 010 while
  // already running keeps the current phase of the prescaler
  wire restart_wr = wr_uc && halted && (new_div == `RTCU_DIV_RUN);

  // summary flag: enabled flags ored
  wire [2:0] enables = mode_q[`RTCU_MC_PER_EN:`RTCU_MC_UPD_EN];
  wire summary = |(flags_q & enables);

  wire [7:0] uc_read = {update_busy_q, divider_run_control_q, periodic_period_field_q};
  wire [7:0] ef_read = {summary, flags_q, 4'h0};

  // control register writes
  always @* begin
    divider_run_control_d = divider_run_control_q;
    periodic_period_field_d = periodic_period_field_q;
    mode_d = mode_q;
    if (wr_uc) begin
      // busy bit is not writable
      divider_run_control_d = new_div;
      periodic_period_field_d = pwdata[`RTCU_UC_RATE_HI:`RTCU_UC_RATE_LO];
    end
    if (wr_mc) begin
      // format bits may change any time; stored time is untouched
      mode_d = pwdata[7:0] & `RTCU_MC_WMASK;
    end
  end

  always @(posedge core_clk) begin
    if (blk_reset) begin
      divider_run_control_q <= `RTCU_DIV_RESET;
      periodic_period_field_q <= 4'h0;
      mode_q <= `RTCU_MC_RESET;
    end else begin
      divider_run_control_q <= divider_run_control_d;
      periodic_period_field_q <= periodic_period_field_d;
      mode_q <= mode_d;
    end
  end

  // divider chain: a full wrap of the prescaler is one second
  wire wrap = running && tick && (prescale_q == `RTCU_PRESCALE_LAST);
  wire do_update = wrap && !mode_q[`RTCU_MC_INHIBIT];

  always @* begin
    prescale_d = prescale_q;
    if (halted) begin
      prescale_d = 15'h0000;
    end else if (running && tick) begin
      prescale_d = prescale_q + 15'h0001;
    end
    if (restart_wr) begin
      // first update falls one restart delay after this write
      prescale_d = `RTCU_PRESCALE_LAST - RESTART_TICKS[14:0] + 15'h0001;
    end
  end

  always @(posedge core_clk) begin
    if (blk_reset) begin
      prescale_q <= 15'h0000;
    end else begin
      prescale_q <= prescale_d;
    end
  end

  // update-in-progress covers the last 16 ticks before the update
  // looks at the next prescaler value, so busy rises on the tick that opens
  // the 16-tick window and falls on the update cycle itself
  wire busy_window = running && !mode_q[`RTCU_MC_INHIBIT] && (prescale_d >= BUSY_START);

  always @(posedge core_clk) begin
    if (blk_reset) begin
      update_busy_q <= 1'b0;
      update_strobe_q <= 1'b0;
    end else begin
      // cleared on the cycle the update is issued
      update_busy_q <= busy_window && !do_update;
      // one update per second leaves time stable for a full second
      update_strobe_q <= do_update;
    end
  end

  // periodic rate: code n of 3..f gives 2^(n-1) ticks; 1 and 2 alias 8 and 9
  reg [14:0] rate_mask;
  always @* begin
    case (periodic_period_field_q)
      4'h1: rate_mask = 15'h007f;
      4'h2: rate_mask = 15'h00ff;
      4'h3: rate_mask = 15'h0003;
      4'h4: rate_mask = 15'h0007;
      4'h5: rate_mask = 15'h000f;
      4'h6: rate_mask = 15'h001f;
      4'h7: rate_mask = 15'h003f;
      4'h8: rate_mask = 15'h007f;
      4'h9: rate_mask = 15'h00ff;
      4'ha: rate_mask = 15'h01ff;
      4'hb: rate_mask = 15'h03ff;
      4'hc: rate_mask = 15'h07ff;
      4'hd: rate_mask = 15'h0fff;
      4'he: rate_mask = 15'h1fff;
      4'hf: rate_mask = 15'h3fff;
      default: rate_mask = 15'h0000;
    endcase
  end

  // fires on the tick that closes each period
  wire rate_on = periodic_period_field_q != 4'h0;
  wire periodic_hit = rate_on && running && tick && ((prescale_q & rate_mask) == rate_mask);

  always @(posedge core_clk) begin
    if (blk_reset) begin
      periodic_strobe_q <= 1'b0;
    end else begin
      periodic_strobe_q <= periodic_hit;
    end
  end

  // event flags: set always; read clears only what the read returned
  reg [2:0] seen_q;
  always @* begin
    flags_d = flags_q;
    if (rd_ef) begin
      flags_d = flags_q & ~seen_q;
    end
    flags_d = flags_d | {periodic_hit, alarm_event, do_update};
  end

  always @(posedge core_clk) begin
    if (blk_reset) begin
      flags_q <= 3'b000;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_q <= |(flags_d & enables);
    end
  end

  // apb slave: no wait states, read data captured in the setup cycle
  always @(posedge core_clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      seen_q <= 3'b000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !mapped;
        seen_q <= flags_q;
        if (!mapped || pwrite) begin
          prdata <= 32'h00000000;
        end else if (hit_uc) begin
          prdata <= {24'h000000, uc_read};
        end else if (hit_mc) begin
          prdata <= {24'h000000, mode_q};
        end else begin
          prdata <= {24'h000000, ef_read};
        end
      end else if (done) begin
        pslverr <= 1'b0;
      end
    end
  end

  // presentation of the hour counter; storage stays 0..23 binary
  reg [4:0] hour_12;
  reg [4:0] hour_rem;
  reg pm;
  reg [4:0] hour_sel;
  reg [7:0] hour_fmt;
  always @* begin
    hour_rem = 5'd0;
    pm = hour_count >= 5'd12;
    if (hour_count == 5'd0) begin
      hour_12 = 5'd12;
    end else if (hour_count > 5'd12) begin
      hour_12 = hour_count - 5'd12;
    end else begin
      hour_12 = hour_count;
    end
    hour_sel = mode_q[`RTCU_MC_24H] ? hour_count : hour_12;
    if (mode_q[`RTCU_MC_BINARY]) begin
      hour_fmt = {3'b000, hour_sel};
    end else if (hour_sel >= 5'd20) begin
      // tens digit is at most 2, so the units fit in the low four bits
      hour_rem = hour_sel - 5'd20;
      hour_fmt = {4'h2, hour_rem[3:0]};
    end else if (hour_sel >= 5'd10) begin
      hour_rem = hour_sel - 5'd10;
      hour_fmt = {4'h1, hour_rem[3:0]};
    end else begin
      hour_fmt = {4'h0, hour_sel[3:0]};
    end
    if (!mode_q[`RTCU_MC_24H] && pm) begin
      hour_fmt[7] = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (blk_reset) begin
      binary_vs_decimal_select <= 1'b0;
      hour_24_select_q <= 1'b0;
      dst_enable_q <= 1'b0;
    end else begin
      binary_vs_decimal_select <= mode_d[`RTCU_MC_BINARY];
      hour_24_select_q <= mode_d[`RTCU_MC_24H];
      dst_enable_q <= mode_d[`RTCU_MC_DST];
    end
  end

  // presentation is not a control field: only the system reset clears it,
  // so a block reset leaves the shown hour consistent with the hour counter
  always @(posedge core_clk) begin
    if (!resetn) begin
      hour_present_q <= 8'h00;
    end else begin
      hour_present_q <= hour_fmt;
    end
  end

endmodule // rtcu_top

// File: sim/rtcu_top_sva.sv
// checker for rtcu_top: apb handshake, mode outputs, update and periodic strobes
// assumes it is bound into rtcu_top and sees only its ports
`timescale 1ns/10ps
module rtcu_checker (
  input wire core_clk,
  input wire resetn,
  input wire rtc_reset_event,
  input wire [4:0] hour_count,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire irq_q,
  input wire update_strobe_q,
  input wire periodic_strobe_q,
  input wire update_busy_q,
  input wire binary_vs_decimal_select,
  input wire hour_24_select_q,
  input wire dst_enable_q,
  input wire [7:0] hour_present_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_pready_after_setup: assert property (psel && !penable |=> pready) else $error("pready late");
  a_pready_single: assert property (pready |=> !pready) else $error("pready held");
  a_mode_follows_write: assert property (psel && penable && pready && pwrite && paddr == 8'h2c && !rtc_reset_event
    |=> {binary_vs_decimal_select, hour_24_select_q, dst_enable_q} == $past(pwdata[2:0])) else $error("mode bits");
  a_busy_before_update: assert property (update_strobe_q |-> $past(update_busy_q) && !update_busy_q)
    else $error("busy around update");
  a_update_pulse: assert property (update_strobe_q |=> !update_strobe_q [*3]) else $error("update pulse");
  a_periodic_pulse: assert property (periodic_strobe_q |=> !periodic_strobe_q [*3]) else $error("periodic pulse");
  a_block_reset_clears: assert property (rtc_reset_event && !psel
    |=> !binary_vs_decimal_select && !hour_24_select_q && !dst_enable_q && !update_busy_q ##1 !irq_q)
    else $error("block reset");
  a_hour_binary_24: assert property (hour_24_select_q && binary_vs_decimal_select && $stable(hour_count)
    && $stable({hour_24_select_q, binary_vs_decimal_select}) |-> hour_present_q == {3'h0, hour_count})
    else $error("hour 24 binary");
  a_afternoon_bit: assert property (!hour_24_select_q && $stable(hour_count) && $stable(hour_24_select_q)
    |-> hour_present_q[7] == (hour_count >= 5'd12)) else $error("afternoon bit");
endmodule // rtcu_checker
bind rtcu_top rtcu_checker rtcu_checker_i (.core_clk, .resetn, .rtc_reset_event, .hour_count, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pready, .irq_q, .update_strobe_q, .periodic_strobe_q, .update_busy_q,
  .binary_vs_decimal_select, .hour_24_select_q, .dst_enable_q, .hour_present_q);

// File: sim/rtcu_top_bench.sv
// self-checking bench for rtcu_top over apb
// assumes a sped-up tick pin (4 core cycles per tick) so one restart fits the run
`timescale 1ns/10ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin errors = errors + 1; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module rtcu_top_bench;
  logic core_clk = 0, resetn = 0, rtc_reset_event = 0, tick_32k_pin = 0, block_enable = 0, alarm_event = 0;
  logic [4:0] hour_count = 0;
  logic [7:0] paddr = 0;
  logic psel = 0, penable = 0, pwrite = 0, er;
  logic [31:0] pwdata = 0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, irq_q, update_strobe_q, periodic_strobe_q, update_busy_q;
  wire binary_vs_decimal_select, hour_24_select_q, dst_enable_q;
  wire [7:0] hour_present_q;
  integer errors = 0, compares = 0, n, m, k;
  logic [4:0] hv [6] = '{5'd15, 5'd15, 5'd15, 5'd0, 5'd0, 5'd23};
  logic [7:0] mv [6] = '{8'h06, 8'h02, 8'h04, 8'h00, 8'h04, 8'h00};
  logic [7:0] ev [6] = '{8'h0f, 8'h15, 8'h83, 8'h12, 8'h0c, 8'h91};
  rtcu_top rtcu_top_i (.core_clk, .resetn, .rtc_reset_event, .tick_32k_pin, .block_enable, .alarm_event,
    .hour_count, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq_q,
    .update_strobe_q, .periodic_strobe_q, .update_busy_q, .binary_vs_decimal_select, .hour_24_select_q,
    .dst_enable_q, .hour_present_q);
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #12;
    forever #100 tick_32k_pin = ~tick_32k_pin;
  end
  task results;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    integer i;
    @(posedge core_clk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    i = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      i = i + 1;
    end
    if (pready !== 1'b1) begin errors = errors + 1; results; end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  function logic pick(input integer w);
    case (w)
      0: pick = periodic_strobe_q;
      1: pick = update_busy_q;
      default: pick = update_strobe_q;
    endcase
  endfunction
  task waitfor(input integer w, input integer lim);
    n = 0;
    @(negedge core_clk);
    while (pick(w) !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n = n + 1;
    end
    if (n >= lim) begin errors = errors + 1; results; end
  endtask
  task pulse_alarm;
    @(posedge core_clk) alarm_event <= 1;
    @(posedge core_clk) alarm_event <= 0;
    repeat (3) @(negedge core_clk);
  endtask
  task t_regs;
    apb(8'h28, 0, 0); `CHK(rd, 32'h0)
    apb(8'h2c, 0, 0); `CHK(rd, 32'h0)
    apb(8'h40, 0, 0); `CHK({er, rd}, {1'b1, 32'h0})
    apb(8'h29, 0, 0); `CHK(er, 1'b1)
    apb(8'h2c, 1, 8'hff); apb(8'h2c, 0, 0); `CHK(rd, 32'hf7)
    `CHK({binary_vs_decimal_select, hour_24_select_q, dst_enable_q}, 3'h7)
    apb(8'h28, 1, 8'hff); apb(8'h28, 0, 0); `CHK(rd, 32'h7f)
  endtask
  task t_hours;
    for (k = 0; k < 6; k = k + 1) begin
      @(posedge core_clk) hour_count <= hv[k];
      apb(8'h2c, 1, mv[k]);
      repeat (3) @(negedge core_clk);
      `CHK(hour_present_q, ev[k])
    end
  endtask
  task t_block_reset;
    @(posedge core_clk) rtc_reset_event <= 1;
    @(posedge core_clk) rtc_reset_event <= 0;
    apb(8'h28, 0, 0); `CHK(rd, 32'h0)
    apb(8'h2c, 0, 0); `CHK(rd, 32'h0)
  endtask
  task t_alarm;
    apb(8'h2c, 1, 8'h00); pulse_alarm; `CHK(irq_q, 1'b0)
    apb(8'h30, 0, 0); `CHK(rd, 32'h20)
    apb(8'h2c, 1, 8'h20); pulse_alarm; `CHK(irq_q, 1'b1)
    apb(8'h30, 0, 0); `CHK(rd, 32'ha0)
    repeat (3) @(negedge core_clk); `CHK(irq_q, 1'b0)
  endtask
  task t_periodic;
    @(posedge core_clk) block_enable <= 1;
    apb(8'h2c, 1, 8'h40);
    for (k = 1; k < 9; k = k + 1) begin
      apb(8'h28, 1, 8'h20 | k[7:0]);
      // let a strobe launched by the previous rate pass first
      @(negedge core_clk);
      waitfor(0, 5000);
      waitfor(0, 5000);
      `CHK(n + 1, (k < 3 ? 64 << k : 1 << (k - 1)) * 4)
      repeat (2) @(negedge core_clk); `CHK(irq_q, 1'b1)
    end
    apb(8'h28, 1, 8'h20);
    repeat (4) @(negedge core_clk);
    m = 0;
    repeat (3000) begin
      @(negedge core_clk);
      if (periodic_strobe_q !== 1'b0) m = m + 1;
    end
    `CHK(m, 0)
    apb(8'h30, 0, 0); `CHK(rd, 32'hc0)
    apb(8'h30, 0, 0); `CHK(rd, 32'h0)
  endtask
  task t_update;
    apb(8'h2c, 1, 8'h10);
    apb(8'h28, 1, 8'h60);
    apb(8'h28, 1, 8'h20);
    waitfor(1, 70000);
    m = n;
    waitfor(2, 200);
    `CHK(n + 1, 64)
    `CHK(update_busy_q, 1'b0)
    `CHK(m + n > 65500 && m + n < 65560, 1'b1)
    repeat (2) @(negedge core_clk); `CHK(irq_q, 1'b1)
    apb(8'h30, 0, 0); `CHK(rd, 32'h90)
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1;
    t_regs;
    t_hours;
    t_block_reset;
    t_alarm;
    t_periodic;
    t_update;
    results;
  end
endmodule // rtcu_top_bench
